// File: eepc_ctrl.sv
// serial prom master: command side on clock_i, bus engine on link_clk_i
// assumes external pull-ups on both lines; pins are open drain
// Operation
// - serial clock runs at 100 kHz
// - loader owns controller while it is active
// - both lines open drain, pull low only
// - strap picks one or two address bytes
// - location bits 10..0 are sent, all 16 with two address bytes
// - start, control byte, address bytes, all acknowledged
// - missing acknowledge aborts and sets timeout
// - control byte carries code 1010b first
// - select bits: address 10..8 or low
// - direction bit low while addressing
// - read: restart, read control, byte, nack, stop
// - sequential read acks all but last byte
// - write: data byte, acknowledge, then stop
// - after write, wait bus free and poll
// - poll timeout 30 ms, checked on nack
// - acked poll ends with start then stop
// - slave may stretch clock low phase
// - clock held low 30 ms aborts
// - 4.7 us bus free after stop
// - busy set starts command, cleared when done
module eepc_ctrl #(
	parameter int unsigned TIMEOUT_CYC = eepc_pkg::TIMEOUT_CYC
) (
	// clocks and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic link_clk_i,
	// requests
	input wire logic sw_req_i,
	input wire eepc_pkg::eepc_req_t sw_cmd_i,
	input wire logic ldr_req_i,
	input wire eepc_pkg::eepc_req_t ldr_cmd_i,
	input wire logic loader_active_i,
	input wire logic prom_size_strap_i,
	// status
	output logic controller_busy_flag_o,
	output logic controller_timeout_flag_o,
	output eepc_pkg::eepc_rd_t rd_o,
	// bus pins
	input wire logic prom_serial_clock_line_i,
	output logic prom_serial_clock_line_o,
	output logic prom_serial_clock_line_oe_n_o,
	input wire logic prom_serial_data_line_i,
	output logic prom_serial_data_line_o,
	output logic prom_serial_data_line_oe_n_o
);
	import eepc_pkg::*;

	localparam logic [TW-1:0] HALF_M1 = TW'(T_HALF_CYC - 1);
	localparam logic [TW-1:0] BUF_M1 = TW'(T_BUF_CYC - 1);
	localparam logic [TW-1:0] TO_M1 = TW'(TIMEOUT_CYC - 1);
	localparam logic [TW-1:0] HALF_CNT = TW'(T_HALF_CYC);

	// ----------------------------------------
	// byte selection
	// ----------------------------------------
	function automatic logic [7:0] byte_for(eepc_phase_t ph, eepc_req_t rq, logic two);
		logic [2:0] sel;
		sel = two ? SEL_LOW : rq.location[10:8];
		case (ph)
			PH_CW: byte_for = {CTRL_CODE, sel, DIR_WR};
			PH_CR: byte_for = {CTRL_CODE, sel, DIR_RD};
			PH_POLL: byte_for = {CTRL_CODE, SEL_LOW, DIR_WR};
			PH_AH: byte_for = rq.location[15:8];
			PH_AL: byte_for = rq.location[7:0];
			default: byte_for = rq.wdata;
		endcase
	endfunction

	eepc_sst_t ss_r;
	eepc_sst_t ss_nxt;
	eepc_lst_t ls_r;
	eepc_lst_t ls_nxt;
	logic [1:0] sys_sync;
	logic [4:0] lsync;
	logic lrst;
	logic go_s;
	logic strap_s;
	logic scl_s;
	logic sda_s;
	logic take_ldr;
	logic take_sw;
	logic [TW-1:0] low_cnt;

	// ----------------------------------------
	// command side
	// ----------------------------------------
	eepc_sync #(.W(2)) u_sys_sync (
		.clk_i(clock_i),
		.d_i({ls_r.done_tgl, ls_r.rd_tgl}),
		.q_o(sys_sync)
	);

	assign take_ldr = ldr_req_i && loader_active_i && !ss_r.busy;
	assign take_sw = sw_req_i && !loader_active_i && !ss_r.busy;

	always_comb begin
		ss_nxt = ss_r;
		ss_nxt.rd.valid = 1'b0;
		ss_nxt.done_q = sys_sync[1];
		ss_nxt.rd_q = sys_sync[0];
		if (take_ldr || take_sw) begin
			ss_nxt.req = take_ldr ? ldr_cmd_i : sw_cmd_i;
			ss_nxt.busy = 1'b1;
			ss_nxt.to = 1'b0;
			ss_nxt.go_tgl = ~ss_r.go_tgl;
		end
		if (ss_r.busy && sys_sync[1] != ss_r.done_q) begin
			ss_nxt.busy = 1'b0;
			ss_nxt.to = ls_r.err;
		end
		if (ss_r.busy && sys_sync[0] != ss_r.rd_q) begin
			ss_nxt.rd.data = ls_r.rbyte;
			ss_nxt.rd.valid = 1'b1;
		end
		if (sys_rst_i) begin
			ss_nxt = '0;
		end
	end

	always_ff @(posedge clock_i) begin
		ss_r <= ss_nxt;
	end

	assign controller_busy_flag_o = ss_r.busy;
	assign controller_timeout_flag_o = ss_r.to;
	assign rd_o = ss_r.rd;

	// ----------------------------------------
	// bus engine
	// ----------------------------------------
	eepc_sync #(.W(5)) u_link_sync (
		.clk_i(link_clk_i),
		.d_i({sys_rst_i, ss_r.go_tgl, prom_size_strap_i,
			prom_serial_clock_line_i, prom_serial_data_line_i}),
		.q_o(lsync)
	);

	assign lrst = lsync[4];
	assign go_s = lsync[3];
	assign strap_s = lsync[2];
	assign scl_s = lsync[1];
	assign sda_s = lsync[0];

	always_comb begin
		logic tdone;
		logic go_stop;
		logic load;
		eepc_phase_t nph;
		tdone = (ls_r.timer == HALF_M1);
		go_stop = 1'b0;
		load = 1'b0;
		nph = ls_r.phase;
		ls_nxt = ls_r;
		ls_nxt.timer = ls_r.timer + TW'(1);
		if (ls_r.phase == PH_POLL && ls_r.pc != TO_M1) begin
			ls_nxt.pc = ls_r.pc + TW'(1);
		end
		case (ls_r.state)
			S_IDLE: begin
				if (go_s != ls_r.go_q) begin
					ls_nxt.go_q = go_s;
					ls_nxt.phase = PH_CW;
					ls_nxt.two = strap_s;
					ls_nxt.fin = 1'b0;
					ls_nxt.err = 1'b0;
					ls_nxt.cnt = ss_r.req.len_m1;
					ls_nxt.state = S_FREE;
				end
			end
			S_FREE: begin
				if (ls_r.timer == BUF_M1) begin
					if (ls_r.fin) begin
						ls_nxt.state = S_DONE;
					end else begin
						ls_nxt.state = S_RISE;
						ls_nxt.ret = S_STHOLD;
						ls_nxt.hi = 1'b0;
					end
				end
			end
			S_RSLOW, S_BLOW, S_PLOW: begin
				if (tdone) begin
					ls_nxt.state = S_RISE;
					ls_nxt.hi = 1'b0;
					ls_nxt.ret = (ls_r.state == S_BLOW) ? S_BEND :
						(ls_r.state == S_PLOW) ? S_PREL : S_STHOLD;
				end
			end
			S_RISE: begin
				if (!ls_r.hi) begin
					if (scl_s) begin
						ls_nxt.hi = 1'b1;
						ls_nxt.timer = '0;
					end else if (ls_r.timer == TO_M1) begin
						ls_nxt.err = 1'b1;
						ls_nxt.state = S_DONE;
					end
				end else if (tdone) begin
					ls_nxt.state = ls_r.ret;
				end
			end
			S_STHOLD: begin
				if (tdone) begin
					if (ls_r.phase == PH_STBY) begin
						ls_nxt.fin = 1'b1;
						ls_nxt.state = S_PLOW;
					end else begin
						load = 1'b1;
					end
				end
			end
			S_BEND: begin
				ls_nxt.sh = {ls_r.sh[7:0], sda_s};
				if (ls_r.bitn != LAST_BIT) begin
					ls_nxt.bitn = ls_r.bitn + 4'h1;
					ls_nxt.state = S_BLOW;
				end else begin
					case (ls_r.phase)
						PH_RD: begin
							ls_nxt.rbyte = ls_r.sh[7:0];
							ls_nxt.rd_tgl = ~ls_r.rd_tgl;
							if (ls_r.cnt != 8'h00) begin
								ls_nxt.cnt = ls_r.cnt - 8'h01;
								load = 1'b1;
							end else begin
								go_stop = 1'b1;
								ls_nxt.fin = 1'b1;
							end
						end
						PH_POLL: begin
							if (!sda_s) begin
								ls_nxt.phase = PH_STBY;
								ls_nxt.state = S_RSLOW;
							end else if (ls_r.pc == TO_M1) begin
								ls_nxt.err = 1'b1;
								ls_nxt.fin = 1'b1;
								go_stop = 1'b1;
							end else begin
								ls_nxt.fin = 1'b0;
								go_stop = 1'b1;
							end
						end
						default: begin
							if (sda_s) begin
								ls_nxt.err = 1'b1;
								ls_nxt.fin = 1'b1;
								go_stop = 1'b1;
							end else begin
								case (ls_r.phase)
									PH_CW: begin
										nph = ls_r.two ? PH_AH : PH_AL;
										load = 1'b1;
									end
									PH_AH: begin
										nph = PH_AL;
										load = 1'b1;
									end
									PH_AL: begin
										if (ss_r.req.op == EEPC_WRITE) begin
											nph = PH_WD;
											load = 1'b1;
										end else begin
											ls_nxt.phase = PH_CR;
											ls_nxt.state = S_RSLOW;
										end
									end
									PH_WD: begin
										ls_nxt.phase = PH_POLL;
										ls_nxt.pc = '0;
										ls_nxt.fin = 1'b0;
										go_stop = 1'b1;
									end
									default: begin
										nph = PH_RD;
										load = 1'b1;
									end
								endcase
							end
						end
					endcase
				end
			end
			S_PREL: begin
				ls_nxt.state = S_FREE;
			end
			S_DONE: begin
				ls_nxt.done_tgl = ~ls_r.done_tgl;
				ls_nxt.state = S_IDLE;
			end
			default: begin
				ls_nxt.state = S_IDLE;
			end
		endcase
		if (load) begin
			ls_nxt.phase = nph;
			ls_nxt.bitn = 4'h0;
			ls_nxt.state = S_BLOW;
			if (nph == PH_RD) begin
				ls_nxt.sh = {RX_IDLE, ls_nxt.cnt == 8'h00};
			end else begin
				ls_nxt.sh = {byte_for(nph, ss_r.req, ls_r.two), 1'b1};
			end
		end
		if (go_stop) begin
			ls_nxt.state = S_PLOW;
		end
		if (ls_nxt.state != ls_r.state) begin
			ls_nxt.timer = '0;
		end
		// line drive: data bits move only once the clock is already low; start and stop move data with the clock high
		case (ls_nxt.state)
			S_BLOW, S_PLOW, S_RSLOW: begin
				ls_nxt.scl_low = 1'b1;
				if (ls_r.state == ls_nxt.state) begin
					ls_nxt.sda_low = (ls_r.state == S_BLOW) ? ~ls_r.sh[8] :
						(ls_r.state == S_PLOW);
				end
			end
			S_STHOLD: begin
				ls_nxt.scl_low = 1'b0;
				ls_nxt.sda_low = 1'b1;
			end
			S_RISE, S_BEND: begin
				ls_nxt.scl_low = 1'b0;
			end
			default: begin
				ls_nxt.scl_low = 1'b0;
				ls_nxt.sda_low = 1'b0;
			end
		endcase
		if (lrst) begin
			ls_nxt = '0;
		end
	end

	always_ff @(posedge link_clk_i) begin
		ls_r <= ls_nxt;
	end

	assign prom_serial_clock_line_o = 1'b0;
	assign prom_serial_data_line_o = 1'b0;
	assign prom_serial_clock_line_oe_n_o = ~ls_r.scl_low;
	assign prom_serial_data_line_oe_n_o = ~ls_r.sda_low;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	always_ff @(posedge link_clk_i) begin
		if (lrst || !ls_r.scl_low) begin
			low_cnt <= '0;
		end else begin
			low_cnt <= low_cnt + TW'(1);
		end
	end

	property p_idle_released;
		@(posedge link_clk_i) disable iff (lrst)
		ls_r.state == S_IDLE |-> !ls_r.scl_low && !ls_r.sda_low;
	endproperty
	a_idle_released: assert property (p_idle_released) else $error("lines held in idle");

	property p_ctrl_code;
		@(posedge link_clk_i) disable iff (lrst)
		(ls_r.state == S_BLOW && ls_r.bitn == 4'h0 && ls_r.phase inside {PH_CW, PH_CR, PH_POLL})
		|-> ls_r.sh[8:5] == CTRL_CODE;
	endproperty
	a_ctrl_code: assert property (p_ctrl_code) else $error("bad control code");

	property p_sel_bits;
		@(posedge link_clk_i) disable iff (lrst)
		(ls_r.state == S_BLOW && ls_r.bitn == 4'h0 && ls_r.phase == PH_CW)
		|-> ls_r.sh[4:2] == (ls_r.two ? SEL_LOW : ss_r.req.location[10:8]);
	endproperty
	a_sel_bits: assert property (p_sel_bits) else $error("bad select bits");

	property p_dir_bit;
		@(posedge link_clk_i) disable iff (lrst)
		(ls_r.state == S_BLOW && ls_r.bitn == 4'h0 && ls_r.phase == PH_CW)
		|-> ls_r.sh[1] == DIR_WR;
	endproperty
	a_dir_bit: assert property (p_dir_bit) else $error("address direction high");

	property p_low_time;
		@(posedge link_clk_i) disable iff (lrst)
		$fell(ls_r.scl_low) |-> low_cnt >= HALF_CNT;
	endproperty
	a_low_time: assert property (p_low_time) else $error("clock low too short");

	property p_nack_abort;
		@(posedge link_clk_i) disable iff (lrst)
		(ls_r.state == S_BEND && ls_r.bitn == LAST_BIT && sda_s
			&& ls_r.phase inside {PH_CW, PH_AH, PH_AL, PH_WD, PH_CR})
		|=> ls_r.err && ls_r.fin && ls_r.state == S_PLOW;
	endproperty
	a_nack_abort: assert property (p_nack_abort) else $error("nack not aborted");

	property p_stretch_abort;
		@(posedge link_clk_i) disable iff (lrst)
		(ls_r.state == S_RISE && !ls_r.hi && !scl_s && ls_r.timer == TO_M1)
		|=> ls_r.err ##1 ls_r.state == S_IDLE;
	endproperty
	a_stretch_abort: assert property (p_stretch_abort) else $error("stretch not aborted");

	property p_poll_retry;
		@(posedge link_clk_i) disable iff (lrst)
		(ls_r.state == S_BEND && ls_r.bitn == LAST_BIT && ls_r.phase == PH_POLL
			&& sda_s && ls_r.pc != TO_M1)
		|=> !ls_r.err && !ls_r.fin && ls_r.state == S_PLOW;
	endproperty
	a_poll_retry: assert property (p_poll_retry) else $error("early poll timeout");

	property p_standby;
		@(posedge link_clk_i) disable iff (lrst)
		(ls_r.state == S_BEND && ls_r.bitn == LAST_BIT && ls_r.phase == PH_POLL && !sda_s)
		|=> ls_r.state == S_RSLOW && ls_r.phase == PH_STBY;
	endproperty
	a_standby: assert property (p_standby) else $error("no standby sequence");

	property p_accept;
		@(posedge clock_i) disable iff (sys_rst_i)
		(sw_req_i && !loader_active_i && !ss_r.busy)
		|=> ss_r.busy && !ss_r.to && ss_r.go_tgl != $past(ss_r.go_tgl);
	endproperty
	a_accept: assert property (p_accept) else $error("request not started");

	property p_loader_excl;
		@(posedge clock_i) disable iff (sys_rst_i)
		(loader_active_i && !ldr_req_i && !ss_r.busy) |=> !ss_r.busy;
	endproperty
	a_loader_excl: assert property (p_loader_excl) else $error("request during loader");

	c_write_done: cover property (@(posedge link_clk_i) disable iff (lrst)
		ls_r.state == S_DONE && !ls_r.err && ls_r.phase == PH_STBY);
	c_read_done: cover property (@(posedge link_clk_i) disable iff (lrst)
		ls_r.state == S_DONE && !ls_r.err && ls_r.phase == PH_RD);
	c_timeout: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		$fell(ss_r.busy) && ss_r.to);

endmodule

// File: eepc_pkg.sv
// constants, types and state records for the serial prom master
// assumes a 100 MHz system clock and a 32 ns link clock
package eepc_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned LINK_NS = 32;
	localparam int unsigned SCL_KHZ = 100;
	localparam int unsigned T_HALF_NS = 1_000_000 / (2 * SCL_KHZ);
	localparam int unsigned T_BUF_NS = 4700;
	localparam int unsigned TIMEOUT_MS = 30;
	localparam int unsigned T_HALF_CYC = (T_HALF_NS + LINK_NS - 1) / LINK_NS;
	localparam int unsigned T_BUF_CYC = (T_BUF_NS + LINK_NS - 1) / LINK_NS;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * 1_000_000 / LINK_NS;
	localparam int TW = 20;

	// ----------------------------------------
	// control byte layout
	// ----------------------------------------
	localparam logic [3:0] CTRL_CODE = 4'ha;
	localparam logic [2:0] SEL_LOW = 3'h0;
	localparam logic DIR_WR = 1'b0;
	localparam logic DIR_RD = 1'b1;
	localparam logic [3:0] LAST_BIT = 4'h8;
	localparam logic [7:0] RX_IDLE = 8'hff;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic {EEPC_READ, EEPC_WRITE} eepc_op_t;

	typedef struct packed {
		eepc_op_t op;
		logic [15:0] location;
		logic [7:0] len_m1;
		logic [7:0] wdata;
	} eepc_req_t;

	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} eepc_rd_t;

	typedef enum logic [3:0] {
		S_IDLE, S_FREE, S_RSLOW, S_RISE, S_STHOLD, S_BLOW, S_BEND, S_PLOW, S_PREL, S_DONE
	} eepc_state_t;

	typedef enum logic [2:0] {
		PH_CW, PH_AH, PH_AL, PH_WD, PH_CR, PH_RD, PH_POLL, PH_STBY
	} eepc_phase_t;

	typedef struct packed {
		eepc_state_t state;
		eepc_state_t ret;
		eepc_phase_t phase;
		logic hi;
		logic [TW-1:0] timer;
		logic [TW-1:0] pc;
		logic [3:0] bitn;
		logic [8:0] sh;
		logic [7:0] cnt;
		logic two;
		logic fin;
		logic err;
		logic scl_low;
		logic sda_low;
		logic go_q;
		logic done_tgl;
		logic rd_tgl;
		logic [7:0] rbyte;
	} eepc_lst_t;

	typedef struct packed {
		logic busy;
		logic to;
		eepc_req_t req;
		logic go_tgl;
		logic done_q;
		logic rd_q;
		eepc_rd_t rd;
	} eepc_sst_t;

endpackage

// File: eepc_sync.sv
// two-stage synchroniser for a bundle of independent levels
// assumes each bit is a level or a toggle held long enough to be seen
module eepc_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [1:0][W-1:0] st_r;
	logic [1:0][W-1:0] st_nxt;

	always_comb begin
		st_nxt = {st_r[0], d_i};
	end

	always_ff @(posedge clk_i) begin
		st_r <= st_nxt;
	end

	// only the second stage is read outside
	assign q_o = st_r[1];

endmodule

// File: eepc_prom_model.sv
// slave model of the serial prom: byte memory, acks, reads, busy polls
// assumes resolved open-drain levels on its inputs, pull-ups high
module eepc_prom_model (
	// bus levels and address-size strap
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic two_i,
	// data pull
	output logic sda_low_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535];
	logic [7:0] sh, ctl, log_q[$];
	logic [15:0] ptr;
	int n, bi = -1, nack_n = 0, starts = 0;
	bit rd = 0, mack, wr = 0;
	initial sda_low_o = 0;
	always @(negedge sda_i) if (scl_i) begin
		n = 0;
		bi = 0;
		rd = 0;
		starts++;
	end
	// a finished write keeps the part busy for one poll
	always @(posedge sda_i) if (scl_i) begin
		bi = -1;
		if (wr) nack_n = 1;
		wr = 0;
	end
	always @(posedge scl_i) if (bi >= 0) begin
		if (n < 8 && !rd) sh = {sh[6:0], sda_i};
		if (n == 8) mack = !sda_i;
		n++;
	end
	always @(negedge scl_i) if (bi >= 0) begin
		if (rd) begin
			if (n == 9 && mack) begin
				ptr++;
				sh = mem[ptr];
				n = 0;
			end else if (n == 9) bi = -1;
			sda_low_o = (n < 8 && bi >= 0) ? !sh[7-n] : 1'b0;
		end else if (n == 8) begin
			log_q.push_back(sh);
			sda_low_o = 1;
			if (bi == 0) begin
				ctl = sh;
				sda_low_o = (nack_n == 0);
				if (nack_n > 0) nack_n--;
			end
			if (bi == 1) ptr = two_i ? {sh, 8'h00} : {5'h00, ctl[3:1], sh};
			if (bi == 2 && two_i) ptr[7:0] = sh;
			if (bi > (two_i ? 2 : 1)) begin
				mem[ptr] = sh;
				ptr++;
				wr = 1;
			end
		end else if (n == 9) begin
			n = 0;
			bi++;
			sda_low_o = 0;
			if (bi == 1 && ctl[0]) begin
				rd = 1;
				sh = mem[ptr];
				sda_low_o = !sh[7];
			end
		end
	end
endmodule

// File: eepc_ctrl_test.sv
// self-checking bench for the serial prom master against the slave model
// assumes eepc_pkg, eepc_sync, eepc_ctrl and the model compiled first
module eepc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import eepc_pkg::*;
	localparam int unsigned TO = 5000;
	logic clock_i = 0, link_clk = 0, sys_rst_i = 1;
	logic sw_req = 0, ldr_req = 0, ldr_act = 0, strap = 0, stretch = 0;
	eepc_req_t sw_cmd = '0, ldr_cmd = '0;
	logic busy, tmo, scl_oe_n, sda_oe_n, scl_o, sda_o, slv_low;
	eepc_rd_t rd;
	wire logic scl = !(scl_oe_n === 1'b0 || stretch);
	wire logic sda = !(sda_oe_n === 1'b0 || slv_low === 1'b1);
	int n_errors = 0, compares = 0, cyc = 0;
	logic [31:0] lfsr_r = 32'h7d6465a2;
	logic [15:0] loc;
	logic [7:0] wd, ref_mem [0:2047], got_q[$], exp_q[$];
	realtime t_rise = 0;

	always #5 clock_i = ~clock_i;
	initial begin
		#3;
		forever #16 link_clk = ~link_clk;
	end

	eepc_ctrl #(.TIMEOUT_CYC(TO)) u_eepc_ctrl (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk),
		.sw_req_i(sw_req), .sw_cmd_i(sw_cmd), .ldr_req_i(ldr_req), .ldr_cmd_i(ldr_cmd),
		.loader_active_i(ldr_act), .prom_size_strap_i(strap),
		.controller_busy_flag_o(busy), .controller_timeout_flag_o(tmo), .rd_o(rd),
		.prom_serial_clock_line_i(scl), .prom_serial_clock_line_o(scl_o),
		.prom_serial_clock_line_oe_n_o(scl_oe_n), .prom_serial_data_line_i(sda),
		.prom_serial_data_line_o(sda_o), .prom_serial_data_line_oe_n_o(sda_oe_n)
	);
	eepc_prom_model u_eepc_prom_model (
		.scl_i(scl), .sda_i(sda), .two_i(strap), .sda_low_o(slv_low)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] ctl(input logic [15:0] a, input logic two, input logic dir);
		return {4'ha, two ? 3'h0 : a[10:8], dir};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic issue(input logic ldr, input eepc_req_t c);
		@(negedge clock_i);
		ldr_cmd = c;
		sw_cmd = c;
		ldr_req = ldr;
		sw_req = !ldr;
		@(negedge clock_i);
		ldr_req = 0;
		sw_req = 0;
	endtask
	task automatic wait_idle();
		int k;
		chk(busy, 1, "busy set");
		for (k = 0; k < 60000 && busy !== 1'b0; k++) @(negedge clock_i);
		chk(busy, 0, "busy clear");
	endtask
	task automatic cmp_log(input int n_st);
		chk(u_eepc_prom_model.log_q.size(), exp_q.size(), "byte count");
		foreach (exp_q[i]) chk(u_eepc_prom_model.log_q[i], exp_q[i], "wire byte");
		chk(u_eepc_prom_model.starts, n_st, "starts");
		u_eepc_prom_model.log_q.delete();
		u_eepc_prom_model.starts = 0;
	endtask

	always @(posedge clock_i) begin
		cyc++;
		if (rd.valid === 1'b1) got_q.push_back(rd.data);
		if (cyc == 150000) begin
			n_errors++;
			$display("MISMATCH at %0t: run too long", $time);
			end_sim();
		end
	end
	// no clock period shorter than the standard rate allows
	always @(posedge scl) if (busy === 1'b1) begin
		if (t_rise > 0 && $realtime - t_rise < 20000) chk($realtime - t_rise >= 10000, 1, "rate");
		t_rise = $realtime;
	end

	initial begin
		for (int i = 0; i < 2048; i++) begin
			lfsr_r = lfsr(lfsr_r);
			ref_mem[i] = lfsr_r[7:0];
			u_eepc_prom_model.mem[i] = lfsr_r[7:0];
		end
		repeat (10) @(negedge clock_i);
		sys_rst_i = 0;
		repeat (10) @(negedge clock_i);
		chk({busy, tmo, scl_oe_n, sda_oe_n}, 4'h3, "reset state");
		// software refused while the loader owns the controller
		ldr_act = 1;
		lfsr_r = lfsr(lfsr_r);
		loc = {5'h00, lfsr_r[10:1], 1'b0};
		issue(0, '{EEPC_READ, loc, 8'h01, 8'h00});
		chk(busy, 0, "sw refused");
		issue(1, '{EEPC_READ, loc, 8'h01, 8'h00});
		wait_idle();
		ldr_act = 0;
		chk(tmo, 0, "read flag");
		exp_q = '{ctl(loc, 0, 0), loc[7:0], ctl(loc, 0, 1)};
		cmp_log(2);
		chk(got_q.size(), 2, "read count");
		chk(got_q[0], ref_mem[loc], "rd0");
		chk(got_q[1], ref_mem[loc+1], "rd1");
		// byte write, one busy poll, then standby
		lfsr_r = lfsr(lfsr_r);
		loc = {5'h00, lfsr_r[10:0]};
		wd = lfsr_r[18:11];
		issue(0, '{EEPC_WRITE, loc, 8'h00, wd});
		wait_idle();
		chk(tmo, 0, "write flag");
		exp_q = '{ctl(loc, 0, 0), loc[7:0], wd, 8'ha0, 8'ha0};
		cmp_log(4);
		chk(u_eepc_prom_model.mem[loc], wd, "stored");
		// control byte refused in two-byte mode
		strap = 1;
		u_eepc_prom_model.nack_n = 1;
		issue(0, '{EEPC_WRITE, loc, 8'h00, wd});
		wait_idle();
		chk(tmo, 1, "nack flag");
		exp_q = '{8'ha0};
		cmp_log(1);
		// clock held low past the limit
		issue(0, '{EEPC_READ, loc, 8'h00, 8'h00});
		chk(tmo, 0, "flag cleared");
		for (int k = 0; k < 3000 && scl !== 1'b0; k++) @(negedge clock_i);
		stretch = 1;
		for (int k = 0; k < 20000 && busy !== 1'b0; k++) @(negedge clock_i);
		chk({busy, tmo, scl_oe_n, sda_oe_n}, 4'h7, "stretch abort");
		stretch = 0;
		chk({scl_o, sda_o}, 0, "pins");
		end_sim();
	end
endmodule
